// file: tb/servo_status_outputs_tb.sv
`timescale 1ns/1ns
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin err_count++; \
  $display("Error %0t got %h exp %h", $time, g, x); end end
module servo_status_outputs_tb import sso_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, enc_step = 1'b0, enc_dir = 1'b0;
  logic ctrl_power_ok = 1'b0, main_power_ok = 1'b0, pready, pslverr, irq, e;
  logic running_detect_out, servo_fault_out, servo_ready_out, speed_match_out, position_done_out;
  logic torque_limit_reached_out, quad_phase_a_out, quad_phase_b_out, zero_point_pulse_out;
  logic [2:0] assign_pin_out;
  logic [7:0] fault_code = 8'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] motor_speed = 16'h0, speed_ref = 16'h0, pos_error = 16'h0, out_torque = 16'h0;
  int err_count = 0, compares = 0, hpos;
  // small encoder size keeps a revolution at 16 counts
  sso_status_top #(.PPR(4)) dut (.*);
  sso_host_model host (.pclk, .pha(quad_phase_a_out), .phb(quad_phase_b_out), .pos(hpos));
  initial forever #5 pclk = ~pclk;
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // request held until pready is seen high; data and error taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    do tick(1); while (pready !== 1'b1);
    e = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask : apb
  task automatic step(input logic d, input int n);
    enc_dir <= d;
    enc_step <= 1'b1;
    tick(n);
    enc_step <= 1'b0;
    tick(3);
  endtask : step
  task automatic end_sim;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////
  task automatic t_regs;
    apb(1'b0, 12'h010, 32'h0);
    `CHK(rd, 32'h0000_012c)
    apb(1'b0, 12'h014, 32'h0);
    `CHK(rd, 32'h0000_0024)
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK({e, rd}, 33'h1_0000_0000)
    $display("regs done");
  endtask : t_regs
  // exactly the threshold is not running, one past it is, either sign
  task automatic t_run;
    apb(1'b1, 12'h004, 32'h0000_0014);
    motor_speed <= 16'h0014;
    tick(2);
    `CHK(running_detect_out, 1'b0)
    motor_speed <= 16'hffeb;
    tick(2);
    `CHK({running_detect_out, assign_pin_out[0]}, 2'b11)
    $display("run done");
  endtask : t_run
  task automatic t_ready;
    for (int i = 0; i < 8; i++) begin
      ctrl_power_ok <= i[0];
      main_power_ok <= i[1];
      fault_code <= i[2] ? 8'h05 : 8'h00;
      tick(2);
      `CHK({servo_ready_out, servo_fault_out}, {i == 3, !i[2]})
    end
    fault_code <= 8'h00;
    $display("ready done");
  endtask : t_ready
  // band and width are 10 out of reset
  task automatic t_match;
    speed_ref <= 16'h0064;
    motor_speed <= 16'h006e;
    pos_error <= 16'hfff6;
    tick(2);
    `CHK({speed_match_out, position_done_out}, 2'b10)
    motor_speed <= 16'h006f;
    tick(2);
    `CHK(speed_match_out, 1'b0)
    apb(1'b1, 12'h000, {30'h0, SSO_MODE_POSITION});
    tick(1);
    `CHK({speed_match_out, position_done_out}, 2'b01)
    pos_error <= 16'h000b;
    tick(2);
    `CHK(position_done_out, 1'b0)
    // torque mode: both raw compares true, yet neither flag may show
    motor_speed <= 16'h006e;
    pos_error <= 16'h0000;
    apb(1'b1, 12'h000, {30'h0, SSO_MODE_TORQUE});
    tick(1);
    `CHK({speed_match_out, position_done_out}, 2'b00)
    $display("match done");
  endtask : t_match
  task automatic t_trq;
    out_torque <= 16'hfed4;
    tick(2);
    `CHK(torque_limit_reached_out, 1'b1)
    out_torque <= 16'h012b;
    apb(1'b1, 12'h014, 32'h0000_0039);
    tick(1);
    `CHK({torque_limit_reached_out, assign_pin_out}, 4'b0001)
    out_torque <= 16'h012c;
    tick(2);
    `CHK(assign_pin_out, 3'b101)
    $display("torque done");
  endtask : t_trq
  // down through zero wraps to the top of the revolution
  task automatic t_quad;
    step(1'b0, 3);
    `CHK({quad_phase_a_out, quad_phase_b_out, zero_point_pulse_out, hpos}, {3'b100, 32'h3})
    step(1'b1, 4);
    `CHK({quad_phase_a_out, quad_phase_b_out, zero_point_pulse_out, hpos}, {3'b100, 32'hffff_ffff})
    step(1'b0, 1);
    `CHK({quad_phase_a_out, quad_phase_b_out, zero_point_pulse_out, hpos}, {3'b001, 32'h0})
    $display("quad done");
  endtask : t_quad
  task automatic t_irq;
    motor_speed <= 16'h0000;
    apb(1'b1, 12'h020, 32'h0000_0001);
    apb(1'b0, 12'h01c, 32'h0);
    motor_speed <= 16'h0030;
    tick(3);
    `CHK(irq, 1'b1)
    apb(1'b0, 12'h01c, 32'h0);
    `CHK({irq, rd}, 33'h0_0000_0001)
    apb(1'b1, 12'h020, 32'h0);
    motor_speed <= 16'h0000;
    tick(2);
    motor_speed <= 16'h0030;
    tick(3);
    `CHK(irq, 1'b0)
    $display("irq done");
  endtask : t_irq
  ////////////////////////////////////////
  initial begin
    tick(2);
    presetn <= 1'b1;
    t_regs;
    t_run;
    t_ready;
    t_match;
    t_trq;
    t_quad;
    t_irq;
    end_sim;
  end
  // the tests need about a hundred cycles
  initial begin
    tick(5000);
    err_count++;
    end_sim;
  end
endmodule : servo_status_outputs_tb

// file: tb/sso_host_model.sv
`timescale 1ns/1ns
// host side: decodes the quadrature pair back into a count
module sso_host_model (
  input wire logic pclk,
  input wire logic pha,
  input wire logic phb,
  output int pos
);
  logic [1:0] q_r = 2'h0;
  int cnt = 0;
  wire logic [1:0] q = {pha, pha ^ phb};
  // a two-bit step of one gives the direction; a jump of two is lost
  always @(posedge pclk) begin
    if (q - q_r == 2'h1) cnt <= cnt + 1;
    else if (q_r - q == 2'h1) cnt <= cnt - 1;
    q_r <= q;
  end
  assign pos = cnt;
endmodule : sso_host_model

// file: tb/sso_status_monitor.sv
`timescale 1ns/1ns
// pin checks on the status top; flags lag their inputs by one cycle
module sso_status_monitor #(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic [W-1:0] motor_speed,
  input wire logic ctrl_power_ok,
  input wire logic main_power_ok,
  input wire logic [7:0] fault_code,
  input wire logic enc_step,
  input wire logic running_detect_out,
  input wire logic servo_fault_out,
  input wire logic servo_ready_out,
  input wire logic speed_match_out,
  input wire logic position_done_out,
  input wire logic quad_phase_a_out,
  input wire logic quad_phase_b_out,
  input wire logic zero_point_pulse_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // past(presetn) skips the first edge, which still shows the reset value
  ready_power_a:
    assert property ($past(presetn) |-> servo_ready_out == ($past(ctrl_power_ok && main_power_ok && fault_code == 8'h00)))
    else $error("ready flag wrong");
  fault_level_a:
    assert property ($past(presetn) |-> servo_fault_out == ($past(fault_code) == 8'h00))
    else $error("fault output wrong");
  still_motor_a:
    assert property ($past(presetn) && !(|$past(motor_speed)) |-> !running_detect_out)
    else $error("running while stopped");
  quad_hold_a:
    assert property (!$past(enc_step) && !$past(enc_step, 2) |-> $stable(quad_phase_a_out) && $stable(quad_phase_b_out))
    else $error("phase moved with no step");
  quad_gray_a:
    assert property (!($changed(quad_phase_a_out) && $changed(quad_phase_b_out)))
    else $error("both phases moved");
  zero_phase_a:
    assert property (zero_point_pulse_out |-> !quad_phase_a_out && !quad_phase_b_out)
    else $error("zero pulse off count zero");
  mode_excl_a:
    assert property (!(speed_match_out && position_done_out))
    else $error("match and done together");
  slverr_phase_a:
    assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
endmodule : sso_status_monitor

bind sso_status_top sso_status_monitor #(.W(W)) mon (.*);

// file: verilog/sso_cmp.sv
`timescale 1ns/1ns
`include "sso_defs.svh"
// magnitude compare helpers for the status flags
module sso_cmp import sso_pkg::*; #(
  parameter int W = 16
) (
  input wire logic [W-1:0] speed,
  input wire logic [W-1:0] speed_ref,
  input wire logic [W-1:0] pos_err,
  input wire logic [W-1:0] torque,
  input wire logic [W-1:0] spd_thr,
  input wire logic [W-1:0] band,
  input wire logic [W-1:0] width,
  input wire logic [W-1:0] trq_lim,
  output logic running,
  output logic matching,
  output logic done,
  output logic at_limit
);
  // speed, error and torque compared as magnitudes; match uses the signed speed difference, so direction counts there
  wire [W-1:0] spd_mag = speed[W-1] ? W'(-speed) : speed;
  wire [W-1:0] err_mag = pos_err[W-1] ? W'(-pos_err) : pos_err;
  wire [W-1:0] trq_mag = torque[W-1] ? W'(-torque) : torque;
  wire signed [W:0] diff = $signed({speed[W-1], speed}) - $signed({speed_ref[W-1], speed_ref});
  wire [W:0] diff_mag = diff[W] ? (W+1)'(-diff) : diff;
  assign running = spd_mag > spd_thr; // [RULE1]
  assign matching = diff_mag <= {1'b0, band}; // [RULE4]
  assign done = err_mag <= width; // [RULE5]
  assign at_limit = trq_mag >= trq_lim; // [RULE6]
endmodule : sso_cmp

// file: verilog/sso_defs.svh
`ifndef SSO_DEFS_SVH
`define SSO_DEFS_SVH
// register byte offsets
`define SSO_REG_CTRL 12'h000
`define SSO_REG_RUN_SPD 12'h004
`define SSO_REG_MATCH_BAND 12'h008
`define SSO_REG_DONE_WIDTH 12'h00c
`define SSO_REG_TRQ_LIMIT 12'h010
`define SSO_REG_PIN_MAP 12'h014
`define SSO_REG_STATUS 12'h018
`define SSO_REG_IRQ_STAT 12'h01c
`define SSO_REG_IRQ_MASK 12'h020
`define SSO_REG_FAULT_CODE 12'h024
// control fields
`define SSO_CTRL_MODE_LSB 0
`define SSO_CTRL_MODE_MSB 1
// pin map fields, 2 bits per assignable pin
`define SSO_MAP_W 2
`define SSO_NUM_PINS 3
// reset values
`define SSO_RST_RUN_SPD 32'h0000_0014
`define SSO_RST_MATCH_BAND 32'h0000_000a
`define SSO_RST_DONE_WIDTH 32'h0000_000a
`define SSO_RST_TRQ_LIMIT 32'h0000_012c
`define SSO_RST_PIN_MAP 6'h24
`define SSO_NUM_EVT 6
`endif

// file: verilog/sso_pkg.sv
package sso_pkg;
  // control mode of the drive
  typedef enum logic [1:0] {
    SSO_MODE_SPEED = 2'h0,
    SSO_MODE_POSITION = 2'h1,
    SSO_MODE_TORQUE = 2'h2
  } sso_mode_t;
  // status function that can be steered to an assignable pin
  typedef enum logic [1:0] {
    SSO_FN_RUNNING = 2'h0,
    SSO_FN_READY = 2'h1,
    SSO_FN_MATCH = 2'h2,
    SSO_FN_TORQUE = 2'h3
  } sso_func_t;
endpackage : sso_pkg

// file: verilog/sso_quad_gen.sv
`timescale 1ns/1ns
`include "sso_defs.svh"
// turns encoder position increments into A/B quadrature and a C zero pulse
module sso_quad_gen import sso_pkg::*; #(
  parameter int PPR = 2500
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step_valid,
  input wire logic step_dir,
  output logic phase_a,
  output logic phase_b,
  output logic phase_c
);
  localparam int CW = $clog2(PPR * 4);
  localparam logic [CW-1:0] LAST = CW'(PPR * 4 - 1);
  logic [CW-1:0] pos_r;
  logic [CW-1:0] pos_nxt;
  wire [1:0] q_gray;
  //////////////////////////////////////////////////////////////
  // position count wraps once per revolution
  assign pos_nxt = !step_valid ? pos_r :
                   step_dir ? ((pos_r == '0) ? LAST : pos_r - 1'b1) :
                   ((pos_r == LAST) ? '0 : pos_r + 1'b1);
  // gray code of low two bits gives one edge per step, never two at once
  assign q_gray = {pos_r[1] ^ 1'b0, pos_r[1] ^ pos_r[0]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_r <= '0;
    end else begin
      pos_r <= pos_nxt;
    end
  end
  // outputs registered so the line drivers see clean edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_a <= 1'b0;
      phase_b <= 1'b0;
      phase_c <= 1'b0;
    end else begin
      phase_a <= q_gray[1]; // [RULE3]
      phase_b <= q_gray[0]; // [RULE3]
      phase_c <= (pos_r == '0); // one zero pulse per revolution [RULE3]
    end
  end
endmodule : sso_quad_gen

// file: verilog/sso_status_top.sv
`timescale 1ns/1ns
`include "sso_defs.svh"
// What this block does
// RULE1 - running flag high while speed magnitude exceeds detection threshold, else low
// RULE2 - ready flag only with control and main power and no alarm
// RULE3 - A/B quadrature from encoder steps plus one C pulse per revolution
// RULE4 - speed mode: match flag when speed within band of reference
// RULE5 - position mode: done flag when error pulses within completion width
// RULE6 - torque-limit flag while torque magnitude has reached limit
// RULE7 - pin map register picks function for each assignable output
// RULE8 - fault output high with no error, low on any fault
module sso_status_top import sso_pkg::*; #(
  parameter int W = 16,
  parameter int PPR = 2500
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [W-1:0] motor_speed,
  input wire logic [W-1:0] speed_ref,
  input wire logic [W-1:0] pos_error,
  input wire logic [W-1:0] out_torque,
  input wire logic ctrl_power_ok,
  input wire logic main_power_ok,
  input wire logic [7:0] fault_code,
  input wire logic enc_step,
  input wire logic enc_dir,
  output logic running_detect_out,
  output logic servo_fault_out,
  output logic servo_ready_out,
  output logic speed_match_out,
  output logic position_done_out,
  output logic torque_limit_reached_out,
  output logic [2:0] assign_pin_out,
  output logic quad_phase_a_out,
  output logic quad_phase_b_out,
  output logic zero_point_pulse_out,
  output logic irq
);
  localparam int NE = `SSO_NUM_EVT;
  localparam int NP = `SSO_NUM_PINS;
  logic [1:0] mode_r;
  logic [W-1:0] run_thr_r;
  logic [W-1:0] band_r;
  logic [W-1:0] width_r;
  logic [W-1:0] tlim_r;
  logic [NP*`SSO_MAP_W-1:0] map_r;
  logic [NE-1:0] ist_r;
  logic [NE-1:0] imask_r;
  logic [NE-1:0] flags_q_r;
  logic [31:0] prdata_r;
  wire running;
  wire matching;
  wire done;
  wire at_limit;
  wire [NP-1:0] pin_nxt;
  //////////////////////////////////////////////////////////////
  // apb decode; pready is tied high, so every access ends in its first cycle
  wire acc = psel && penable;
  wire setup_ph = psel && !penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  // read data loads in setup so it already stands at the completing edge
  wire rd_load = setup_ph && !pwrite;
  wire hit_ctrl = paddr == `SSO_REG_CTRL;
  wire hit_run = paddr == `SSO_REG_RUN_SPD;
  wire hit_band = paddr == `SSO_REG_MATCH_BAND;
  wire hit_width = paddr == `SSO_REG_DONE_WIDTH;
  wire hit_tlim = paddr == `SSO_REG_TRQ_LIMIT;
  wire hit_map = paddr == `SSO_REG_PIN_MAP;
  wire hit_stat = paddr == `SSO_REG_STATUS;
  wire hit_ist = paddr == `SSO_REG_IRQ_STAT;
  wire hit_imask = paddr == `SSO_REG_IRQ_MASK;
  wire hit_fc = paddr == `SSO_REG_FAULT_CODE;
  wire mapped = hit_ctrl | hit_run | hit_band | hit_width | hit_tlim | hit_map |
                hit_stat | hit_ist | hit_imask | hit_fc;
  // one write strobe per writable register
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_run = wr && hit_run;
  wire wr_band = wr && hit_band;
  wire wr_width = wr && hit_width;
  wire wr_tlim = wr && hit_tlim;
  wire wr_map = wr && hit_map;
  wire wr_imask = wr && hit_imask;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped; // unmapped addresses error, read zero
  assign prdata = prdata_r;
  //////////////////////////////////////////////////////////////
  // flag derivation
  sso_cmp #(.W(W)) u_cmp (
    .speed(motor_speed),
    .speed_ref(speed_ref),
    .pos_err(pos_error),
    .torque(out_torque),
    .spd_thr(run_thr_r),
    .band(band_r),
    .width(width_r),
    .trq_lim(tlim_r),
    .running(running),
    .matching(matching),
    .done(done),
    .at_limit(at_limit)
  );
  wire is_speed = mode_r == SSO_MODE_SPEED;
  wire is_pos = mode_r == SSO_MODE_POSITION;
  wire fault = |fault_code;
  wire ready = ctrl_power_ok && main_power_ok && !fault; // [RULE2]
  wire match_q = is_speed && matching; // [RULE4]
  wire done_q = is_pos && done; // [RULE5]
  // shared pin carries match in speed mode, done in position mode
  wire shared_fn = is_speed ? match_q : done_q;
  wire [3:0] fn_vec = {at_limit, shared_fn, ready, running};
  wire [NE-1:0] flags = {fault, at_limit, done_q, match_q, ready, running};
  wire [NE-1:0] ev = flags & ~flags_q_r; // rising edges are events
  //////////////////////////////////////////////////////////////
  // control mode; a mode change retargets the shared pin at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= SSO_MODE_SPEED;
    end else if (wr_ctrl) begin
      mode_r <= pwdata[`SSO_CTRL_MODE_MSB:`SSO_CTRL_MODE_LSB];
    end
  end
  // running detection threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_thr_r <= W'(`SSO_RST_RUN_SPD);
    end else if (wr_run) begin
      run_thr_r <= pwdata[W-1:0];
    end
  end
  // speed match tolerance band
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      band_r <= W'(`SSO_RST_MATCH_BAND);
    end else if (wr_band) begin
      band_r <= pwdata[W-1:0];
    end
  end
  // positioning completion width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_r <= W'(`SSO_RST_DONE_WIDTH);
    end else if (wr_width) begin
      width_r <= pwdata[W-1:0];
    end
  end
  // torque limit level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tlim_r <= W'(`SSO_RST_TRQ_LIMIT);
    end else if (wr_tlim) begin
      tlim_r <= pwdata[W-1:0];
    end
  end
  // pin steering map
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_r <= `SSO_RST_PIN_MAP;
    end else if (wr_map) begin
      map_r <= pwdata[NP*`SSO_MAP_W-1:0]; // [RULE7]
    end
  end
  // interrupt mask, same layout as the status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_r <= '0;
    end else if (wr_imask) begin
      imask_r <= pwdata[NE-1:0];
    end
  end
  //////////////////////////////////////////////////////////////
  // sticky events; a read clears only what it reported in setup,
  // so an event landing between setup and access is not lost
  wire ist_rd = rd && hit_ist;
  wire [NE-1:0] ist_clr = ist_rd ? prdata_r[NE-1:0] : '0;
  wire [NE-1:0] ist_nxt = (ist_r & ~ist_clr) | ev; // set wins over clear
  // event status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= '0;
    end else begin
      ist_r <= ist_nxt;
    end
  end
  // last flags, for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q_r <= '0;
    end else begin
      flags_q_r <= flags;
    end
  end
  // read mux
  wire [31:0] rdmux =
    hit_ctrl ? 32'(mode_r) :
    hit_run ? 32'(run_thr_r) :
    hit_band ? 32'(band_r) :
    hit_width ? 32'(width_r) :
    hit_tlim ? 32'(tlim_r) :
    hit_map ? 32'(map_r) :
    hit_stat ? 32'(flags) :
    hit_ist ? 32'(ist_r) :
    hit_imask ? 32'(imask_r) :
    hit_fc ? 32'(fault_code) : '0;
  // read data register; holds between reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (rd_load) begin
      prdata_r <= rdmux;
    end
  end
  //////////////////////////////////////////////////////////////
  // each assignable pin picks one function through its map field
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pin
      wire [`SSO_MAP_W-1:0] sel = map_r[gi*`SSO_MAP_W +: `SSO_MAP_W];
      assign pin_nxt[gi] = fn_vec[sel]; // [RULE7]
    end
  endgenerate
  // assignable pins, registered like the fixed ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      assign_pin_out <= '0;
    end else begin
      assign_pin_out <= pin_nxt; // [RULE7]
    end
  end
  //////////////////////////////////////////////////////////////
  // running detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_detect_out <= 1'b0;
    end else begin
      running_detect_out <= running; // [RULE1]
    end
  end
  // fault output; low in reset, so a host sees no healthy drive early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_fault_out <= 1'b0;
    end else begin
      servo_fault_out <= !fault; // on while healthy [RULE8]
    end
  end
  // servo ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_ready_out <= 1'b0;
    end else begin
      servo_ready_out <= ready; // [RULE2]
    end
  end
  // speed match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_match_out <= 1'b0;
    end else begin
      speed_match_out <= match_q; // [RULE4]
    end
  end
  // positioning done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position_done_out <= 1'b0;
    end else begin
      position_done_out <= done_q; // [RULE5]
    end
  end
  // torque limit reached
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      torque_limit_reached_out <= 1'b0;
    end else begin
      torque_limit_reached_out <= at_limit; // [RULE6]
    end
  end
  // interrupt level; uses next status so it rises with the event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ist_nxt & imask_r);
    end
  end
  //////////////////////////////////////////////////////////////
  // encoder pulse outputs
  sso_quad_gen #(.PPR(PPR)) u_quad (
    .pclk(pclk),
    .presetn(presetn),
    .step_valid(enc_step),
    .step_dir(enc_dir),
    .phase_a(quad_phase_a_out),
    .phase_b(quad_phase_b_out),
    .phase_c(zero_point_pulse_out)
  );
endmodule : sso_status_top
